// ==== hdl/ebc_pkg.sv ====
package ebc_pkg;

    localparam int unsigned EBC_REGIONS    = 4;
    localparam int unsigned EBC_ADDR_W     = 24;
    localparam int unsigned EBC_DATA_W     = 16;

    // Register byte offsets
    localparam logic [11:0] EBC_OFF_CFG0   = 12'h000;
    localparam logic [11:0] EBC_OFF_CFG1   = 12'h004;
    localparam logic [11:0] EBC_OFF_CFG2   = 12'h008;
    localparam logic [11:0] EBC_OFF_CFG3   = 12'h00C;
    localparam logic [11:0] EBC_OFF_ADDR   = 12'h010;
    localparam logic [11:0] EBC_OFF_WDATA  = 12'h014;
    localparam logic [11:0] EBC_OFF_CMD    = 12'h018;
    localparam logic [11:0] EBC_OFF_STATUS = 12'h01C;
    localparam logic [11:0] EBC_OFF_CLKCTL = 12'h020;

    // region_timing_config fields
    localparam int unsigned EBC_F_SETUP    = 0;
    localparam int unsigned EBC_F_WEXT     = 1;
    localparam int unsigned EBC_F_CMDDLY   = 3;
    localparam int unsigned EBC_F_WSET     = 5;
    localparam int unsigned EBC_F_ACCESS   = 6;
    localparam int unsigned EBC_F_HOLD     = 11;
    localparam int unsigned EBC_F_RDY_EN   = 13;
    localparam int unsigned EBC_F_RDY_POL  = 14;
    localparam int unsigned EBC_F_RDY_ASYN = 15;
    localparam int unsigned EBC_F_MUX      = 16;
    localparam int unsigned EBC_CFG_BITS   = 17;

    // Command and status fields
    localparam int unsigned EBC_C_WRITE    = 0;
    localparam int unsigned EBC_C_BYTE_HI  = 1;
    localparam int unsigned EBC_S_BUSY     = 0;
    localparam int unsigned EBC_S_RDATA    = 16;

    // Reset values
    localparam logic [31:0] EBC_CFG_RST    = 32'h0000_0000;
    localparam logic [23:0] EBC_ADDR_RST   = 24'h00_0000;
    localparam logic [15:0] EBC_DATA_RST   = 16'h0000;
    localparam logic [1:0]  EBC_WIN_RST    = 2'h0;
    localparam logic [4:0]  EBC_CNT_RST    = 5'h00;

    localparam logic [1:0]  EBC_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  EBC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        EBC_IDLE   = 3'h0,
        EBC_SETUP  = 3'h1,
        EBC_CMD    = 3'h3,
        EBC_WSET   = 3'h2,
        EBC_ACCESS = 3'h6,
        EBC_HOLD   = 3'h7
    } ebc_state_t;

endpackage

// ==== hdl/ebc_ready_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module ebc_ready_sync
    import ebc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_in,
    output logic      sync_out,
    output logic      late_out
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // Two stages for the pin, a third for asynchronous use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign sync_out = stage2_reg;
    assign late_out = stage3_reg;
endmodule
`default_nettype wire

// ==== hdl/ebc_bus_controller.sv ====
// What this block does
// - Five phases: setup, command, write setup, access, hold
// - Phase lengths come from addressed region config
// - Ready input may stretch access when enabled
// - Setup 1-2 periods, plus 0-3 on window change
// - Command 0-3, turnaround 0-1, access 1-32, hold 0-3
// - Read data captured when read strobe rises
// - Address held stable from start until the cycle ends
// - Reference clock is system clock, driver enabled by clock control register
// - 24-bit address; mux or separate data lines
// - Software selects ready polarity
// - Asynchronous ready takes an extra synchroniser stage
// - Ready inactive inserts wait, active ends cycle
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ebc_bus_controller
    import ebc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             bus_reference_clock,
    output logic             bus_clock_drive_en,
    output logic [23:0]      address_lines,
    output logic [15:0]      shared_addr_data_lines_o,
    output logic             shared_addr_data_lines_oe,
    input  wire logic [15:0] shared_addr_data_lines_i,
    output logic [15:0]      separate_data_lines_o,
    output logic             separate_data_lines_oe,
    input  wire logic [15:0] separate_data_lines_i,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic             addr_latch_strobe,
    output logic             byte_high_enable_n,
    output logic [3:0]       chip_select_n,
    input  wire logic        ready_in
);
    logic [31:0] cfg_reg [EBC_REGIONS];
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic        clkctl_reg;
    logic [31:0] cur_cfg_reg;
    logic        cur_write_reg;
    logic        cur_byte_hi_reg;
    logic [23:0] bus_addr_reg;
    logic [15:0] bus_wdata_reg;
    logic [1:0]  prev_win_reg;
    ebc_state_t  state_reg;
    ebc_state_t  state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_in_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_out_reg;
    logic [1:0]  rresp_reg;
    logic        ready_s2;
    logic        ready_s3;
    logic        ready_act;
    logic        do_write;
    logic        start;
    logic        busy;
    logic        multiplexed_mode;
    logic [1:0]  cmd_len;
    logic [1:0]  hold_len;
    logic [4:0]  acc_m1;
    logic        wset_en;

    ebc_ready_sync u_ready_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   (ready_in),
        .sync_out (ready_s2),
        .late_out (ready_s3)
    );

    assign multiplexed_mode = cur_cfg_reg[EBC_F_MUX];
    assign cmd_len  = cur_cfg_reg[EBC_F_CMDDLY +: 2];
    assign hold_len = cur_cfg_reg[EBC_F_HOLD +: 2];
    assign acc_m1   = cur_cfg_reg[EBC_F_ACCESS +: 5];
    assign wset_en  = cur_cfg_reg[EBC_F_WSET];
    assign busy     = (state_reg != EBC_IDLE);
    // Extra stage when asynchronous; polarity from software
    assign ready_act = (cur_cfg_reg[EBC_F_RDY_ASYN] ? ready_s3 : ready_s2)
                       == cur_cfg_reg[EBC_F_RDY_POL];

    // AXI4-Lite write channels
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;
    assign start         = do_write && (awaddr_reg == EBC_OFF_CMD) && !busy
                           && wstrb_reg[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            awaddr_reg   <= 12'h000;
            wdata_in_reg <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= EBC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg   <= 1'b1;
                wdata_in_reg <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (awaddr_reg > EBC_OFF_CLKCTL) ? EBC_RESP_SLVERR
                                                             : EBC_RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Register file with byte strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < EBC_REGIONS; i++)
            begin
                cfg_reg[i] <= EBC_CFG_RST;
            end
            addr_reg   <= EBC_ADDR_RST;
            wdata_reg  <= EBC_DATA_RST;
            clkctl_reg <= 1'b0;
        end
        else if (do_write)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wstrb_reg[b] && awaddr_reg[11:4] == 8'h00)
                begin
                    cfg_reg[awaddr_reg[3:2]][b*8 +: 8] <= wdata_in_reg[b*8 +: 8];
                end
                if (wstrb_reg[b] && b < 3 && awaddr_reg == EBC_OFF_ADDR)
                begin
                    addr_reg[b*8 +: 8] <= wdata_in_reg[b*8 +: 8];
                end
                if (wstrb_reg[b] && b < 2 && awaddr_reg == EBC_OFF_WDATA)
                begin
                    wdata_reg[b*8 +: 8] <= wdata_in_reg[b*8 +: 8];
                end
            end
            if (wstrb_reg[0] && awaddr_reg == EBC_OFF_CLKCTL)
            begin
                clkctl_reg <= wdata_in_reg[0];
            end
        end
    end

    // AXI4-Lite read channels
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_out_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg    <= 1'b0;
            rdata_out_reg <= 32'h0000_0000;
            rresp_reg     <= EBC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg    <= 1'b1;
            rresp_reg     <= EBC_RESP_OKAY;
            rdata_out_reg <= 32'h0000_0000;
            case ({s_axi_araddr[11:2], 2'b00})
                EBC_OFF_CFG0, EBC_OFF_CFG1, EBC_OFF_CFG2, EBC_OFF_CFG3:
                    rdata_out_reg <= {15'h0000,
                                      cfg_reg[s_axi_araddr[3:2]][EBC_CFG_BITS-1:0]};
                EBC_OFF_ADDR:   rdata_out_reg <= {8'h00, addr_reg};
                EBC_OFF_WDATA:  rdata_out_reg <= {16'h0000, wdata_reg};
                EBC_OFF_CMD:    rdata_out_reg <= 32'h0000_0000;
                EBC_OFF_STATUS: rdata_out_reg <= {rdata_reg, 15'h0000, busy};
                EBC_OFF_CLKCTL: rdata_out_reg <= {31'h0000_0000, clkctl_reg};
                default:        rresp_reg     <= EBC_RESP_SLVERR;
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // Phase sequencer
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            EBC_IDLE:
            begin
                if (start)
                begin
                    state_next = EBC_SETUP;
                    cnt_next   = {4'h0, cfg_reg[addr_reg[23:22]][EBC_F_SETUP]}
                                 + ((addr_reg[23:22] != prev_win_reg)
                                   ? {3'h0, cfg_reg[addr_reg[23:22]][EBC_F_WEXT +: 2]}
                                   : 5'h00);
                end
            end
            EBC_SETUP, EBC_CMD, EBC_WSET:
            begin
                if (cnt_reg != 5'h00)
                begin
                    cnt_next = cnt_reg - 5'h01;
                end
                else if (state_reg == EBC_SETUP && cmd_len != 2'h0)
                begin
                    state_next = EBC_CMD;
                    cnt_next   = {3'h0, cmd_len - 2'h1};
                end
                else if (state_reg != EBC_WSET && wset_en)
                begin
                    state_next = EBC_WSET;
                    cnt_next   = EBC_CNT_RST;
                end
                else
                begin
                    state_next = EBC_ACCESS;
                    cnt_next   = acc_m1;
                end
            end
            EBC_ACCESS:
            begin
                if (cnt_reg != 5'h00)
                begin
                    cnt_next = cnt_reg - 5'h01;
                end
                else if (cur_cfg_reg[EBC_F_RDY_EN] && !ready_act)
                begin
                    state_next = EBC_ACCESS;
                end
                else if (hold_len != 2'h0)
                begin
                    state_next = EBC_HOLD;
                    cnt_next   = {3'h0, hold_len - 2'h1};
                end
                else
                begin
                    state_next = EBC_IDLE;
                end
            end
            EBC_HOLD:
            begin
                if (cnt_reg != 5'h00)
                begin
                    cnt_next = cnt_reg - 5'h01;
                end
                else
                begin
                    state_next = EBC_IDLE;
                end
            end
            default:
            begin
                state_next = EBC_IDLE;
                cnt_next   = EBC_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= EBC_IDLE;
            cnt_reg   <= EBC_CNT_RST;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Access context latched at start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_cfg_reg   <= EBC_CFG_RST;
            cur_write_reg <= 1'b0;
            cur_byte_hi_reg <= 1'b0;
            bus_addr_reg  <= EBC_ADDR_RST;
            bus_wdata_reg <= EBC_DATA_RST;
            prev_win_reg  <= EBC_WIN_RST;
        end
        else if (start)
        begin
            cur_cfg_reg   <= cfg_reg[addr_reg[23:22]];
            cur_write_reg <= wdata_in_reg[EBC_C_WRITE];
            cur_byte_hi_reg <= wdata_in_reg[EBC_C_BYTE_HI];
            bus_addr_reg  <= addr_reg;
            bus_wdata_reg <= wdata_reg;
            prev_win_reg  <= addr_reg[23:22];
        end
    end

    // Read data taken on the edge that raises the read strobe
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_reg <= EBC_DATA_RST;
        end
        else if (state_reg == EBC_ACCESS && state_next != EBC_ACCESS && !cur_write_reg)
        begin
            rdata_reg <= multiplexed_mode ? shared_addr_data_lines_i
                                  : separate_data_lines_i;
        end
    end

    // Pin drive
    assign bus_reference_clock = aclk;
    assign bus_clock_drive_en  = clkctl_reg;
    assign address_lines       = bus_addr_reg;
    assign read_strobe_n       = !(state_reg == EBC_ACCESS && !cur_write_reg);
    assign write_strobe_n      = !(state_reg == EBC_ACCESS && cur_write_reg);
    assign addr_latch_strobe   = (state_reg == EBC_SETUP) && multiplexed_mode;
    assign byte_high_enable_n  = !(busy && cur_byte_hi_reg);
    assign shared_addr_data_lines_o = (state_reg == EBC_SETUP || state_reg == EBC_CMD)
                                      ? bus_addr_reg[15:0] : bus_wdata_reg;
    assign shared_addr_data_lines_oe = multiplexed_mode && busy
                                       && (state_reg == EBC_SETUP || state_reg == EBC_CMD
                                           || cur_write_reg);
    assign separate_data_lines_o  = bus_wdata_reg;
    assign separate_data_lines_oe = !multiplexed_mode && cur_write_reg
                                    && (state_reg == EBC_WSET || state_reg == EBC_ACCESS
                                        || state_reg == EBC_HOLD);

    for (genvar g = 0; g < EBC_REGIONS; g++)
    begin : g_cs
        assign chip_select_n[g] = !(busy && bus_addr_reg[23:22] == g);
    end

    // Checks
    logic [4:0] age_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_next != state_reg)
        begin
            age_reg <= 5'h00;
        end
        else if (age_reg != 5'h1F)
        begin
            age_reg <= age_reg + 5'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence leave_s(ebc_state_t st);
        state_reg == st && state_next != st;
    endsequence

    phase_order_a: assert property (
        leave_s(EBC_SETUP) |-> state_next inside {EBC_CMD, EBC_WSET, EBC_ACCESS})
        else $error("Setup left for wrong phase");
    cmd_length_a: assert property (
        leave_s(EBC_CMD) |-> age_reg == {3'h0, cmd_len - 2'h1})
        else $error("Command delay length wrong");
    setup_length_a: assert property (
        leave_s(EBC_SETUP) |-> age_reg <= 5'h04 && age_reg >= {4'h0, cur_cfg_reg[0]})
        else $error("Setup length out of range");
    access_min_a: assert property (
        leave_s(EBC_ACCESS) |-> age_reg >= acc_m1)
        else $error("Access phase too short");
    ready_wait_a: assert property (
        state_reg == EBC_ACCESS && cnt_reg == 5'h00 && cur_cfg_reg[EBC_F_RDY_EN]
        && !ready_act |=> state_reg == EBC_ACCESS)
        else $error("Wait state not inserted");
    read_capture_a: assert property (
        $rose(read_strobe_n) |-> rdata_reg == $past(multiplexed_mode ? shared_addr_data_lines_i
                                                             : separate_data_lines_i))
        else $error("Read data not captured at strobe end");
    hold_to_idle_a: assert property (
        leave_s(EBC_HOLD) |-> state_next == EBC_IDLE ##1 state_reg == EBC_IDLE)
        else $error("Next access overlaps hold");
    chip_select_a: assert property (
        (busy |-> $countones(~chip_select_n) == 1) and (!read_strobe_n |-> busy))
        else $error("Chip select wrong during access");
    ale_phase_a: assert property (
        addr_latch_strobe |-> state_reg == EBC_SETUP && multiplexed_mode
                              && !chip_select_n[bus_addr_reg[23:22]])
        else $error("Address latch outside setup");
    addr_stable_a: assert property (
        busy && $past(busy) |-> $stable(address_lines))
        else $error("Address moved during access");
endmodule
`default_nettype wire

// ==== hdl/ebc_dummy_unused.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== sim/ebc_ext_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module ebc_ext_mem (
    input  wire logic        aclk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [3:0]  cs_n,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wr_bus,
    input  wire logic [7:0]  rdy_wait,
    input  wire logic        rdy_pol,
    output logic      [15:0] dout,
    output logic             rdy,
    output logic      [15:0] last_wr
);
    logic [15:0] word = 16'h0000;
    logic [7:0]  busy_cnt = 8'h00;
    always @(posedge aclk)
    begin
        if (cs_n != 4'hF && rd_n) word <= addr[15:0] ^ 16'h5A5A;
        if (!wr_n) last_wr <= wr_bus;
        busy_cnt <= (rd_n && wr_n) ? 8'h00 : busy_cnt + 8'h01;
    end
    // Released lines show the inverse word, never a held copy
    assign dout = rd_n ? ~word : word;
    assign rdy = (busy_cnt >= rdy_wait) ? rdy_pol : ~rdy_pol;
endmodule
`default_nettype wire

// ==== sim/ebc_bus_controller_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module ebc_bus_controller_bench
    import ebc_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, bus_reference_clock, bus_clock_drive_en, read_strobe_n;
    logic        write_strobe_n, addr_latch_strobe, byte_high_enable_n, ready_in, ready_pol;
    logic        shared_addr_data_lines_oe, separate_data_lines_oe, cs_idle;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [3:0]  s_axi_wstrb, chip_select_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] address_lines, adr_seen;
    logic [15:0] shared_addr_data_lines_o, shared_addr_data_lines_i, separate_data_lines_o;
    logic [15:0] separate_data_lines_i, ext_data, last_write, mux_adr;
    logic [7:0]  ready_wait;
    int          failures, check_count, ticks;
    int          cnt [5];

    ebc_bus_controller i_ebc_bus_controller (.*);
    ebc_ext_mem i_ebc_ext_mem (.aclk, .rd_n(read_strobe_n), .wr_n(write_strobe_n),
        .cs_n(chip_select_n), .addr(address_lines), .wr_bus(separate_data_lines_o),
        .rdy_wait(ready_wait), .rdy_pol(ready_pol), .dout(ext_data), .rdy(ready_in),
        .last_wr(last_write));
    assign shared_addr_data_lines_i = shared_addr_data_lines_oe ? shared_addr_data_lines_o
                                                                : ext_data;
    assign separate_data_lines_i = separate_data_lines_oe ? separate_data_lines_o : ext_data;

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Counts 0 cs, 1 strobe, 2 latch, 3 byte high, 4 starts
    always @(negedge aclk)
    begin
        if (chip_select_n != 4'hF) cnt[0]++;
        if (!(read_strobe_n && write_strobe_n)) cnt[1]++;
        if (addr_latch_strobe) cnt[2]++;
        if (addr_latch_strobe) mux_adr = shared_addr_data_lines_i;
        if (!byte_high_enable_n) cnt[3]++;
        if (chip_select_n != 4'hF && cs_idle) cnt[4]++;
        if (chip_select_n != 4'hF && cs_idle) adr_seen = address_lines;
        cs_idle = (chip_select_n == 4'hF);
        ticks++;
        if (ticks == 20000)
        begin
            failures++;
            $display("[ERR] %0t run timed out", $time);
            final_report();
        end
    end

    task automatic final_report();
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic access(input logic [23:0] a, input logic [1:0] cmd, input logic dbl,
                          input logic [15:0] d);
        logic [1:0] r;
        axi_wr(EBC_OFF_ADDR, {8'h00, a}, r);
        axi_wr(EBC_OFF_WDATA, {16'h0000, d}, r);
        cnt = '{default: 0};
        axi_wr(EBC_OFF_CMD, {30'h0, cmd}, r);
        if (dbl) axi_wr(EBC_OFF_CMD, {30'h0, cmd}, r);
        do
        begin
            axi_rd(EBC_OFF_STATUS, st, r);
        end
        while (st[EBC_S_BUSY] !== 1'b0);
    endtask

    task automatic t_regs();
        logic [1:0] r;
        chk({read_strobe_n, write_strobe_n, chip_select_n, shared_addr_data_lines_oe,
             separate_data_lines_oe}, 8'hFC, "idle pins");
        axi_wr(EBC_OFF_CLKCTL, 32'h0000_0001, r);
        chk(bus_clock_drive_en, 1'b1, "clock driver");
        @(negedge aclk);
        #1;
        chk(bus_reference_clock, 1'b0, "ref clock low");
        #3;
        chk(bus_reference_clock, 1'b1, "ref clock high");
        axi_wr(12'h024, 32'h0000_0001, r);
        chk(r, EBC_RESP_SLVERR, "unmapped write");
        axi_rd(12'h024, st, r);
        chk(st, 32'h0000_0000, "unmapped read data");
        chk(r, EBC_RESP_SLVERR, "unmapped read");
    endtask

    task automatic t_read_basic();
        access(24'h00_1234, 2'b10, 1'b0, 16'h0000);
        chk(cnt[0], 2, "cycle length");
        chk(cnt[1], 1, "strobe length");
        chk(cnt[3], 2, "byte high");
        chk(adr_seen, 24'h00_1234, "address");
        chk(st[31:16], 16'h486E, "read data");
    endtask

    task automatic t_write_shape();
        logic [1:0] r;
        axi_wr(EBC_OFF_CFG1, 32'h0000_18F7, r);
        axi_rd(EBC_OFF_CFG1, st, r);
        chk(st, 32'h0000_18F7, "config readback");
        access(24'h40_0010, 2'b01, 1'b0, 16'hBEEF);
        chk(cnt[0], 15, "shaped cycle");
        chk(cnt[1], 4, "write strobe");
        chk(last_write, 16'hBEEF, "write data");
        access(24'h40_0012, 2'b01, 1'b0, 16'h1357);
        chk(cnt[0], 12, "same window");
    endtask

    task automatic t_long_busy();
        logic [1:0] r;
        axi_wr(EBC_OFF_CFG2, 32'h0000_07C0, r);
        access(24'h80_00F0, 2'b00, 1'b1, 16'h0000);
        chk(cnt[4], 1, "start while busy");
        chk(cnt[0], 33, "longest access");
        chk(st[31:16], 16'h5AAA, "long read");
    endtask

    task automatic t_ready();
        logic [1:0] r;
        int s1;
        axi_wr(EBC_OFF_CFG3, 32'h0001_6000, r);
        ready_pol <= 1'b1;
        ready_wait <= 8'h04;
        access(24'hC0_0ABC, 2'b00, 1'b0, 16'h0000);
        s1 = cnt[1];
        chk(cnt[2], 1, "latch strobe");
        chk(mux_adr, 16'h0ABC, "muxed address");
        chk(st[31:16], 16'h50E6, "muxed read");
        ready_wait <= 8'h08;
        access(24'hC0_0ABC, 2'b00, 1'b0, 16'h0000);
        chk(cnt[1] - s1, 4, "ready waits");
        s1 = cnt[1];
        ready_pol <= 1'b0;
        axi_wr(EBC_OFF_CFG3, 32'h0001_2000, r);
        access(24'hC0_0ABC, 2'b00, 1'b0, 16'h0000);
        chk(cnt[1], s1, "low active ready");
        axi_wr(EBC_OFF_CFG3, 32'h0001_A000, r);
        access(24'hC0_0ABC, 2'b00, 1'b0, 16'h0000);
        chk(cnt[1], s1 + 1, "async ready");
    endtask

    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ready_wait, ready_pol} = '0;
        s_axi_wstrb = 4'hF;
        cs_idle = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_read_basic();
        t_write_shape();
        t_long_busy();
        t_ready();
        final_report();
    end
endmodule
`default_nettype wire
